// ===== bio_defs.vh
// constants for the banked i/o window and the transmit control engine
// assumes a 50 mhz system clock and a 16-location host i/o window
`ifndef BIO_DEFS_VH
`define BIO_DEFS_VH

// ==========================================================
// window layout (byte offsets, dword index = offset[3:2])
`define BIO_OFS_TX_CTRL      4'h0
`define BIO_OFS_TX_STATUS    4'h2
`define BIO_OFS_BANK_SEL     4'he
`define BIO_DW_BANK0         2'h0
`define BIO_DW_BANK_SEL      2'h3
`define BIO_BANK_TX          3'h0
`define BIO_BANK_EXT         3'h7
`define BIO_EXT_ADDR_BIT     3

// ==========================================================
// bank selector fields
`define BIO_BANK_SEL_RST     3'h0
// arbitrary probe signature
`define BIO_SIGNATURE        8'h5a

// ==========================================================
// transmit control bit positions and reset value
`define BIO_TC_TX_EN         0
`define BIO_TC_PHY_LOOP      1
`define BIO_TC_FORCE_COL     2
`define BIO_TC_PAD_EN        7
`define BIO_TC_CRC_SUPP      8
`define BIO_TC_CARR_MON      10
`define BIO_TC_RX_OWN        11
`define BIO_TC_STOP_SQE      12
`define BIO_TC_INT_LOOP      13
`define BIO_TC_SW_FDUP       15
`define BIO_TC_WMASK         16'hbd87
`define BIO_TC_RST           16'h0000

// ==========================================================
// transmit status bit positions
`define BIO_TS_SQE           5
`define BIO_TS_TX_EN         6
`define BIO_TS_LATE_COL      9
`define BIO_TS_LOST_CARRIER_FLAG     10

// ==========================================================
// frame constants
`define BIO_MIN_FRAME        11'd64
`define BIO_LATE_COL_BYTES   11'd64
`define BIO_PREAMBLE         8'h55
`define BIO_SFD              8'hd5
`define BIO_PAD_BYTE         8'h00
`define BIO_MAX_COLL         5'd16

// ==========================================================
// timing, times in ns, rate in mhz
`define BIO_CLK_MHZ          50
`define BIO_IFG_NS           960
`define BIO_SQE_DLY_NS       800
`define BIO_SQE_WIN_NS       1600
`define BIO_IFG_CYC          ((`BIO_IFG_NS * `BIO_CLK_MHZ) / 1000)
`define BIO_SQE_DLY_CYC      ((`BIO_SQE_DLY_NS * `BIO_CLK_MHZ) / 1000)
`define BIO_SQE_WIN_CYC      ((`BIO_SQE_WIN_NS * `BIO_CLK_MHZ) / 1000)
`define BIO_SLOT_CYC         512
`endif

// ===== bio_host_model.sv
// host cpu model for the banked i/o window
// assumes one-cycle strobes, answer registered on the take edge and sampled 1 ns after it
`timescale 1ns/1ps

module bio_host_model (
	input  wire        i_ref_clk,
	input  wire [31:0] i_rdata,
	output reg         o_valid,
	output reg         o_rd,
	output reg         o_wr,
	output reg  [3:2]  o_addr,
	output reg  [3:0]  o_be,
	output reg  [31:0] o_wdata
);
	initial begin
		o_valid = 1'b0;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_addr = 2'h0;
		o_be = 4'h0;
		o_wdata = 32'h0000_0000;
	end
	// one access; data lines show inverse data once released
	task xfer(input rd, input [1:0] a, input [3:0] be, input [31:0] d, output [31:0] q);
		begin
			@(posedge i_ref_clk);
			o_valid <= 1'b1;
			o_rd <= rd;
			o_wr <= ~rd;
			o_addr <= a;
			o_be <= be;
			o_wdata <= d;
			@(posedge i_ref_clk);
			o_valid <= 1'b0;
			o_rd <= 1'b0;
			o_wr <= 1'b0;
			o_wdata <= ~d;
			#1 q = i_rdata;
		end
	endtask
endmodule

// ===== bio_pin_gate.v
// pin stage: selects mii or serial inputs and forces pins during loopback
// assumes all pin inputs are synchronous to i_ref_clk
`timescale 1ns/1ps
`include "bio_defs.vh"

module bio_pin_gate (
	input  wire       i_ref_clk,
	input  wire       i_rst_n,
	input  wire       i_int_loop,
	input  wire       i_mii_select,
	input  wire       i_mii_carrier_in,
	input  wire       i_serial_carrier_in,
	input  wire       i_mii_collision_in,
	input  wire       i_serial_collision_in,
	input  wire       i_rx_valid_in,
	input  wire       i_rx_error_in,
	input  wire       i_tx_active,
	input  wire [7:0] i_tx_octet,
	output wire       o_carrier,
	output wire       o_collision,
	output reg        o_rx_valid_ff,
	output reg        o_rx_error_ff,
	output reg  [7:0] o_tx_octet_ff,
	output reg        o_mii_tx_enable_out_ff,
	output reg        o_serial_tx_enable_out_ff,
	output reg        o_serial_txd_ff,
	output reg        o_loop_valid_ff,
	output reg  [7:0] o_loop_octet_ff
);

	// ==========================================================
	// input blocking
	assign o_carrier   = ~i_int_loop &
		(i_mii_select ? i_mii_carrier_in : i_serial_carrier_in);
	assign o_collision = ~i_int_loop &
		(i_mii_select ? i_mii_collision_in : i_serial_collision_in);

	// ==========================================================
	// output forcing
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_rx_valid_ff             <= 1'b0;
			o_rx_error_ff             <= 1'b0;
			o_tx_octet_ff             <= 8'h00;
			o_mii_tx_enable_out_ff    <= 1'b0;
			o_serial_tx_enable_out_ff <= 1'b0;
			o_serial_txd_ff           <= 1'b1;
			o_loop_valid_ff           <= 1'b0;
			o_loop_octet_ff           <= 8'h00;
		end else begin
			o_rx_valid_ff             <= ~i_int_loop & i_rx_valid_in;
			o_rx_error_ff             <= ~i_int_loop & i_rx_error_in;
			o_tx_octet_ff             <= i_int_loop ? 8'h00 : i_tx_octet;
			o_mii_tx_enable_out_ff    <= ~i_int_loop & i_tx_active & i_mii_select;
			o_serial_tx_enable_out_ff <= ~i_int_loop & i_tx_active & ~i_mii_select;
			o_serial_txd_ff           <= i_int_loop | ~i_tx_active | i_tx_octet[0];
			o_loop_valid_ff           <= i_int_loop & i_tx_active;
			o_loop_octet_ff           <= i_int_loop ? i_tx_octet : 8'h00;
		end
	end

endmodule

// ===== bio_properties.sv
// checker for the banked host window of bio_top
// assumes it is bound to bio_top and sees only that module's ports
`timescale 1ns/1ps

module bio_properties #(
	parameter SLOT_CYC = 512
) (
	input wire        i_ref_clk,
	input wire        i_rst_n,
	input wire        i_io_valid,
	input wire        i_io_rd,
	input wire        i_io_wr,
	input wire [3:2]  i_io_addr,
	input wire [3:0]  i_io_be,
	input wire [31:0] i_io_wdata,
	input wire [31:0] o_io_rdata_ff,
	input wire        o_external_reg_select_n_ff,
	input wire        o_phy_loopback_pin_ff,
	input wire        o_rx_accept_own_ff
);
	// ==========================================================
	// shadow of the bank field
	reg  [2:0] bank_ff;
	wire       rd_c = i_io_valid & i_io_rd;
	wire       wr0  = i_io_valid & i_io_wr & (i_io_addr == 2'h0) & (bank_ff == 3'h0);
	always @(posedge i_ref_clk) begin
		if (!i_rst_n)
			bank_ff <= 3'h0;
		else if (i_io_valid & i_io_wr & (i_io_addr == 2'h3) & i_io_be[2])
			bank_ff <= i_io_wdata[18:16];
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	a_ext_sel_bank7: assert property (o_external_reg_select_n_ff == !$past(i_io_valid &
		(i_io_rd | i_io_wr) & ~i_io_addr[3] & (bank_ff == 3'h7))) else $error("ext select wrong");
	a_sig_byte: assert property (rd_c & (i_io_addr == 2'h3) & i_io_be[3] |=>
		o_io_rdata_ff[31:24] == 8'h5a) else $error("signature byte wrong");
	a_bank_field: assert property (rd_c & (i_io_addr == 2'h3) & i_io_be[2] |=>
		o_io_rdata_ff[23:16] == {5'h00, bank_ff}) else $error("bank field wrong");
	a_res_lanes: assert property (rd_c & (i_io_addr == 2'h3) |=>
		o_io_rdata_ff[15:0] == 16'h0000) else $error("lanes at Ch not zero");
	a_bank_gate: assert property (rd_c & (i_io_addr == 2'h0) & (bank_ff != 3'h0) |=>
		o_io_rdata_ff == 32'h0000_0000) else $error("unselected bank answered");
	a_mid_words: assert property (rd_c & i_io_addr[3] != i_io_addr[2] |=>
		o_io_rdata_ff == 32'h0000_0000) else $error("middle words not zero");
	a_rdata_idle: assert property (!rd_c |=> o_io_rdata_ff == 32'h0000_0000)
		else $error("read data not idle");
	a_phy_pin: assert property (wr0 & i_io_be[0] |=>
		o_phy_loopback_pin_ff == $past(i_io_wdata[1])) else $error("loopback pin wrong");
	a_own_accept: assert property (wr0 & i_io_be[1] |=> o_rx_accept_own_ff ==
		($past(i_io_wdata[11]) & ~$past(i_io_wdata[15]))) else $error("own accept wrong");
endmodule

bind bio_top bio_properties #(.SLOT_CYC(SLOT_CYC)) chk_u (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_io_valid(i_io_valid), .i_io_rd(i_io_rd),
	.i_io_wr(i_io_wr), .i_io_addr(i_io_addr), .i_io_be(i_io_be), .i_io_wdata(i_io_wdata),
	.o_io_rdata_ff(o_io_rdata_ff), .o_external_reg_select_n_ff(o_external_reg_select_n_ff),
	.o_phy_loopback_pin_ff(o_phy_loopback_pin_ff), .o_rx_accept_own_ff(o_rx_accept_own_ff));

// ===== bio_top.v
// banked host register window with transmit control and a byte-rate tx engine
// assumes a host i/o bus with dword index, byte enables and one-cycle strobes
//
// Behaviour
// - sixteen-byte window split into banks, top word selects the bank
// - offset reaches even byte or word, offset plus one reaches odd byte
// - every register accepts dword, word or byte transfers
// - three-bit bank field, resets to zero, reachable in every bank
// - upper byte of bank selector always reads a fixed signature
// - selector at Ch dword, Eh word, Eh byte; Ch dword writes only selector
// - bank 7 with address bit 3 low asserts external register select
// - hard reset clears transmit control, disabling transmit and options
// - switched full duplex ignores carrier, never defers, stops collision counting
// - full duplex collision: one-clock jam and backoff, preamble finished first
// - full duplex disables own-frame and carrier-monitor bits
// - internal loopback forces tx pins idle and blocks line inputs
// - stop-on-sqe halts transmitter on sqe failure, otherwise continue
// - own-frame bit lets self-sourced frames through the filter
// - carrier monitor aborts frame without crc when own carrier missing
// - crc suppress omits appended crc, otherwise device inserts it
// - padding appends zero bytes until frame reaches 64 bytes
// - forced collision skips deferral; empty queue sends preamble on carrier
// - late collision from forced collision clears transmit enable
// - loopback bit drives the phy loopback pin directly
// - clearing enable finishes current frame; errors clear enable
// - collision past 64 bytes without switched full duplex jams, flags late collision, disables transmit
`timescale 1ns/1ps
`include "bio_defs.vh"

module bio_top #(
	parameter SLOT_CYC = `BIO_SLOT_CYC
) (
	input  wire        i_ref_clk,
	input  wire        i_rst_n,
	input  wire        i_io_valid,
	input  wire        i_io_rd,
	input  wire        i_io_wr,
	input  wire [3:2]  i_io_addr,
	input  wire [3:0]  i_io_be,
	input  wire [31:0] i_io_wdata,
	output reg  [31:0] o_io_rdata_ff,
	output reg         o_external_reg_select_n_ff,
	input  wire        i_frame_queued,
	input  wire [10:0] i_frame_byte_count,
	input  wire [7:0]  i_tx_data,
	output reg         o_tx_data_ready_ff,
	output reg         o_frame_done_ff,
	input  wire        i_sqe_seen,
	input  wire        i_mii_select,
	input  wire        i_mii_carrier_in,
	input  wire        i_serial_carrier_in,
	input  wire        i_mii_collision_in,
	input  wire        i_serial_collision_in,
	input  wire        i_rx_valid_in,
	input  wire        i_rx_error_in,
	output wire        o_rx_valid_ff,
	output wire        o_rx_error_ff,
	output wire [7:0]  o_tx_octet_ff,
	output wire        o_mii_tx_enable_out_ff,
	output wire        o_serial_tx_enable_out_ff,
	output wire        o_serial_txd_ff,
	output wire        o_loop_valid_ff,
	output wire [7:0]  o_loop_octet_ff,
	output reg         o_phy_loopback_pin_ff,
	output reg         o_rx_accept_own_ff
);

	localparam S_IDLE = 4'd0;
	localparam S_PRE  = 4'd1;
	localparam S_DATA = 4'd2;
	localparam S_PAD  = 4'd3;
	localparam S_CRC  = 4'd4;
	localparam S_JAM  = 4'd5;
	localparam S_BOFF = 4'd6;
	localparam S_IFG  = 4'd7;
	localparam S_SQE  = 4'd8;

	localparam [15:0] IFG_CYC = `BIO_IFG_CYC;
	localparam [15:0] SQE_DLY = `BIO_SQE_DLY_CYC;
	localparam [15:0] SQE_END = `BIO_SQE_DLY_CYC + `BIO_SQE_WIN_CYC;
	localparam [15:0] SLOT    = SLOT_CYC;

	// ==========================================================
	// helpers
	function [31:0] crc_step;
		input [31:0] c;
		input [7:0]  d;
		integer      k;
		reg   [31:0] r;
		begin
			r = c;
			for (k = 0; k < 8; k = k + 1) begin
				if (r[0] ^ d[k])
					r = (r >> 1) ^ 32'hedb8_8320;
				else
					r = r >> 1;
			end
			crc_step = r;
		end
	endfunction

	function [7:0] lane;
		input [31:0] w;
		input [1:0]  n;
		begin
			lane = w[8*n +: 8];
		end
	endfunction

	// ==========================================================
	// state
	reg  [2:0]  bank_sel_field_ff;
	reg  [15:0] transmit_control_ff;
	reg         lost_carrier_flag_ff;
	reg         late_collision_flag_ff;
	reg         sqe_test_flag_ff;
	reg  [3:0]  state_ff;
	reg  [15:0] cnt_ff;
	reg  [10:0] byte_cnt_ff;
	reg  [10:0] len_ff;
	reg  [4:0]  coll_cnt_ff;
	reg  [31:0] crc_ff;
	reg  [7:0]  octet_ff;
	reg         active_ff;
	reg         col_pend_ff;
	reg         pre_only_ff;
	reg         retry_ff;
	reg         sqe_ok_ff;
	reg  [7:0]  lfsr_ff;

	wire        carrier;
	wire        collision;

	wire        tx_en      = transmit_control_ff[`BIO_TC_TX_EN];
	wire        sw_fdup    = transmit_control_ff[`BIO_TC_SW_FDUP];
	wire        force_col  = transmit_control_ff[`BIO_TC_FORCE_COL];
	wire        carr_mon   = transmit_control_ff[`BIO_TC_CARR_MON] & ~sw_fdup;
	wire        wr         = i_io_valid & i_io_wr;
	wire        rd         = i_io_valid & i_io_rd;
	wire        sel_dw     = i_io_addr == `BIO_DW_BANK_SEL;
	wire        bank_tx    = bank_sel_field_ff == `BIO_BANK_TX;
	// selector dword leaves Ch/Dh untouched and bank-0 decode gated by bank
	wire        tc_hit     = wr & bank_tx & (i_io_addr == `BIO_DW_BANK0);
	wire [15:0] be_mask    = {{8{i_io_be[1]}}, {8{i_io_be[0]}}};
	wire        tc_set_en  = tc_hit & i_io_be[`BIO_TC_TX_EN / 8] &
		i_io_wdata[`BIO_TC_TX_EN];
	wire [15:0] transmit_status = {5'h00, lost_carrier_flag_ff,
		late_collision_flag_ff, 2'h0, tx_en, sqe_test_flag_ff, 5'h00};

	reg  [15:0] nxt_tc;
	reg  [3:0]  nxt_state;
	reg  [15:0] nxt_cnt;
	reg         hw_clr_en;
	reg         set_lost;
	reg         set_late;
	reg         set_sqe;
	reg         done;
	reg  [31:0] rdata;

	// ==========================================================
	// register window
	always @* begin
		rdata = 32'h0000_0000;
		if (sel_dw)
			rdata[31:16] = {`BIO_SIGNATURE, 5'h00, bank_sel_field_ff};
		else if (bank_tx && i_io_addr == `BIO_DW_BANK0)
			rdata = {transmit_status, transmit_control_ff};
		rdata = rdata & {{8{i_io_be[3]}}, {8{i_io_be[2]}},
			{8{i_io_be[1]}}, {8{i_io_be[0]}}};
	end

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			bank_sel_field_ff          <= `BIO_BANK_SEL_RST;
			o_io_rdata_ff              <= 32'h0000_0000;
			o_external_reg_select_n_ff <= 1'b1;
		end else begin
			if (wr && sel_dw && i_io_be[2])
				bank_sel_field_ff <= i_io_wdata[18:16];
			o_io_rdata_ff <= rd ? rdata : 32'h0000_0000;
			o_external_reg_select_n_ff <= ~(i_io_valid & (i_io_rd | i_io_wr) &
				(bank_sel_field_ff == `BIO_BANK_EXT) &
				~i_io_addr[`BIO_EXT_ADDR_BIT]);
		end
	end

	// ==========================================================
	// transmit control register
	always @* begin
		nxt_tc = transmit_control_ff;
		if (tc_hit)
			nxt_tc = (transmit_control_ff & ~(be_mask & `BIO_TC_WMASK)) |
				(i_io_wdata[15:0] & be_mask & `BIO_TC_WMASK);
		if (hw_clr_en)
			nxt_tc[`BIO_TC_TX_EN] = 1'b0;
	end

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			transmit_control_ff    <= `BIO_TC_RST;
			lost_carrier_flag_ff   <= 1'b0;
			late_collision_flag_ff <= 1'b0;
			sqe_test_flag_ff       <= 1'b0;
			o_phy_loopback_pin_ff  <= 1'b0;
			o_rx_accept_own_ff     <= 1'b0;
		end else begin
			transmit_control_ff    <= nxt_tc;
			lost_carrier_flag_ff   <= set_lost | (lost_carrier_flag_ff & ~tc_set_en);
			late_collision_flag_ff <= set_late | (late_collision_flag_ff & ~tc_set_en);
			sqe_test_flag_ff       <= set_sqe | (sqe_test_flag_ff & ~tc_set_en);
			o_phy_loopback_pin_ff  <= nxt_tc[`BIO_TC_PHY_LOOP];
			o_rx_accept_own_ff     <= nxt_tc[`BIO_TC_RX_OWN] &
				~nxt_tc[`BIO_TC_SW_FDUP];
		end
	end

	// ==========================================================
	// transmit engine, one octet per clock
	always @* begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff + 16'd1;
		hw_clr_en = 1'b0;
		set_lost  = 1'b0;
		set_late  = 1'b0;
		set_sqe   = 1'b0;
		done      = 1'b0;
		case (state_ff)
			S_IDLE: begin
				nxt_cnt = 16'd0;
				if (tx_en && i_frame_queued && (sw_fdup || force_col || !carrier))
					nxt_state = S_PRE;
				else if (tx_en && force_col && !i_frame_queued && carrier)
					nxt_state = S_PRE;
			end
			S_PRE: begin
				if (pre_only_ff && cnt_ff == 16'd6) begin
					nxt_state = S_IFG;
					nxt_cnt   = 16'd0;
				end else if (cnt_ff == 16'd7) begin
					nxt_cnt = 16'd0;
					if (col_pend_ff || collision)
						nxt_state = S_JAM;
					else if (carr_mon && !carrier) begin
						nxt_state = S_IFG;
						set_lost  = 1'b1;
						hw_clr_en = 1'b1;
						done      = 1'b1;
					end else
						nxt_state = S_DATA;
				end
			end
			S_DATA, S_PAD, S_CRC: begin
				if (collision) begin
					nxt_cnt   = 16'd0;
					nxt_state = S_JAM;
					if (!sw_fdup && byte_cnt_ff >= `BIO_LATE_COL_BYTES) begin
						set_late  = 1'b1;
						hw_clr_en = 1'b1;
					end else if (!sw_fdup && coll_cnt_ff == `BIO_MAX_COLL - 5'd1)
						hw_clr_en = 1'b1;
				end else if (carr_mon && !carrier && state_ff != S_CRC) begin
					nxt_state = S_IFG;
					nxt_cnt   = 16'd0;
					set_lost  = 1'b1;
					hw_clr_en = 1'b1;
					done      = 1'b1;
				end else if (state_ff == S_CRC) begin
					if (cnt_ff == 16'd3) begin
						nxt_state = S_SQE;
						nxt_cnt   = 16'd0;
					end
				end else if (byte_cnt_ff + 11'd1 >= len_ff &&
					(!transmit_control_ff[`BIO_TC_PAD_EN] ||
					byte_cnt_ff + 11'd1 >= `BIO_MIN_FRAME)) begin
					nxt_cnt   = 16'd0;
					nxt_state = transmit_control_ff[`BIO_TC_CRC_SUPP] ?
						S_SQE : S_CRC;
				end else if (byte_cnt_ff + 11'd1 >= len_ff)
					nxt_state = S_PAD;
			end
			S_JAM: begin
				if (sw_fdup || cnt_ff == 16'd3) begin
					nxt_cnt   = 16'd0;
					nxt_state = retry_ff ? S_BOFF : S_IFG;
					done      = ~retry_ff;
				end
			end
			S_BOFF: begin
				if (sw_fdup || cnt_ff >= SLOT * {8'h00, lfsr_ff & ((8'h01 <<
					coll_cnt_ff[2:0]) - 8'h01)}) begin
					nxt_state = S_IFG;
					nxt_cnt   = 16'd0;
				end
			end
			S_SQE: begin
				if (sw_fdup) begin
					nxt_state = S_IFG;
					nxt_cnt   = 16'd0;
					done      = 1'b1;
				end else if (i_mii_select || cnt_ff == SQE_END) begin
					nxt_state = S_IFG;
					nxt_cnt   = 16'd0;
					done      = 1'b1;
					if (i_mii_select || !sqe_ok_ff) begin
						set_sqe   = 1'b1;
						hw_clr_en = transmit_control_ff[`BIO_TC_STOP_SQE];
					end
				end
			end
			S_IFG: begin
				if (cnt_ff >= IFG_CYC - 16'd1)
					nxt_state = S_IDLE;
			end
			default: nxt_state = S_IDLE;
		endcase
	end

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_ff           <= S_IDLE;
			cnt_ff             <= 16'd0;
			byte_cnt_ff        <= 11'd0;
			len_ff             <= 11'd0;
			coll_cnt_ff        <= 5'd0;
			crc_ff             <= 32'hffff_ffff;
			octet_ff           <= 8'h00;
			active_ff          <= 1'b0;
			col_pend_ff        <= 1'b0;
			pre_only_ff        <= 1'b0;
			retry_ff           <= 1'b0;
			sqe_ok_ff          <= 1'b0;
			lfsr_ff            <= 8'h01;
			o_tx_data_ready_ff <= 1'b0;
			o_frame_done_ff    <= 1'b0;
		end else begin
			state_ff           <= nxt_state;
			cnt_ff             <= nxt_cnt;
			lfsr_ff            <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^
				lfsr_ff[4] ^ lfsr_ff[3]};
			o_frame_done_ff    <= done;
			o_tx_data_ready_ff <= nxt_state == S_DATA;
			active_ff          <= nxt_state == S_PRE || nxt_state == S_DATA ||
				nxt_state == S_PAD || nxt_state == S_CRC || nxt_state == S_JAM;
			if (state_ff == S_IDLE) begin
				len_ff      <= i_frame_byte_count & 11'h7fe;
				pre_only_ff <= ~i_frame_queued;
				byte_cnt_ff <= 11'd0;
				crc_ff      <= 32'hffff_ffff;
				col_pend_ff <= 1'b0;
				sqe_ok_ff   <= 1'b0;
			end
			if (state_ff == S_PRE && collision)
				col_pend_ff <= 1'b1;
			if (state_ff == S_SQE && cnt_ff >= SQE_DLY && i_sqe_seen)
				sqe_ok_ff <= 1'b1;
			if (nxt_state == S_JAM && state_ff != S_JAM)
				retry_ff <= sw_fdup | (~set_late & (coll_cnt_ff != `BIO_MAX_COLL - 5'd1));
			if (nxt_state == S_JAM && state_ff != S_JAM && !sw_fdup)
				coll_cnt_ff <= coll_cnt_ff + 5'd1;
			if (done)
				coll_cnt_ff <= 5'd0;
			case (nxt_state)
				S_PRE:   octet_ff <= (nxt_cnt == 16'd7) ? `BIO_SFD : `BIO_PREAMBLE;
				S_DATA:  octet_ff <= i_tx_data;
				S_PAD:   octet_ff <= `BIO_PAD_BYTE;
				S_CRC:   octet_ff <= ~lane(crc_ff, nxt_cnt[1:0]);
				S_JAM:   octet_ff <= 8'haa;
				default: octet_ff <= 8'h00;
			endcase
			if (nxt_state == S_DATA || nxt_state == S_PAD) begin
				crc_ff <= crc_step(crc_ff, nxt_state == S_DATA ? i_tx_data : `BIO_PAD_BYTE);
				if (state_ff == S_DATA || state_ff == S_PAD)
					byte_cnt_ff <= byte_cnt_ff + 11'd1;
			end
		end
	end

	// ==========================================================
	// pin stage
	bio_pin_gate u_pin (
		.i_ref_clk                 (i_ref_clk),
		.i_rst_n                   (i_rst_n),
		.i_int_loop                (transmit_control_ff[`BIO_TC_INT_LOOP]),
		.i_mii_select              (i_mii_select),
		.i_mii_carrier_in          (i_mii_carrier_in),
		.i_serial_carrier_in       (i_serial_carrier_in),
		.i_mii_collision_in        (i_mii_collision_in),
		.i_serial_collision_in     (i_serial_collision_in),
		.i_rx_valid_in             (i_rx_valid_in),
		.i_rx_error_in             (i_rx_error_in),
		.i_tx_active               (active_ff),
		.i_tx_octet                (octet_ff),
		.o_carrier                 (carrier),
		.o_collision               (collision),
		.o_rx_valid_ff             (o_rx_valid_ff),
		.o_rx_error_ff             (o_rx_error_ff),
		.o_tx_octet_ff             (o_tx_octet_ff),
		.o_mii_tx_enable_out_ff    (o_mii_tx_enable_out_ff),
		.o_serial_tx_enable_out_ff (o_serial_tx_enable_out_ff),
		.o_serial_txd_ff           (o_serial_txd_ff),
		.o_loop_valid_ff           (o_loop_valid_ff),
		.o_loop_octet_ff           (o_loop_octet_ff)
	);

endmodule

// ===== bio_top_test.sv
// self-checking bench for bio_top: register window, loopback and one padded frame
// assumes bio_host_model and the bound checker are compiled before it
`timescale 1ns/1ps

module bio_top_test;
	reg         clk, rst_n, queued, mii_sel, mii_crs, rx_v, rx_e;
	reg  [10:0] byte_cnt;
	reg  [7:0]  tx_d, c55, cd5, cdat, cpad, cdone;
	reg  [31:0] q;
	wire        valid, rd, wr, ready, done, ext_n, rxv, rxe, mtx, stx, txd, pin;
	wire [3:2]  addr;
	wire [3:0]  be;
	wire [31:0] wdata, rdata;
	wire [7:0]  oct;
	integer     err_count, n_tests, i;

	bio_host_model host_u (.i_ref_clk(clk), .i_rdata(rdata), .o_valid(valid), .o_rd(rd),
		.o_wr(wr), .o_addr(addr), .o_be(be), .o_wdata(wdata));
	bio_top #(.SLOT_CYC(4)) dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_io_valid(valid),
		.i_io_rd(rd), .i_io_wr(wr), .i_io_addr(addr), .i_io_be(be), .i_io_wdata(wdata),
		.o_io_rdata_ff(rdata), .o_external_reg_select_n_ff(ext_n), .i_frame_queued(queued),
		.i_frame_byte_count(byte_cnt), .i_tx_data(tx_d), .o_tx_data_ready_ff(ready),
		.o_frame_done_ff(done), .i_sqe_seen(1'b0), .i_mii_select(mii_sel),
		.i_mii_carrier_in(mii_crs), .i_serial_carrier_in(1'b0), .i_mii_collision_in(1'b0),
		.i_serial_collision_in(1'b0), .i_rx_valid_in(rx_v), .i_rx_error_in(rx_e),
		.o_rx_valid_ff(rxv), .o_rx_error_ff(rxe), .o_tx_octet_ff(oct),
		.o_mii_tx_enable_out_ff(mtx), .o_serial_tx_enable_out_ff(stx), .o_serial_txd_ff(txd),
		.o_loop_valid_ff(), .o_loop_octet_ff(), .o_phy_loopback_pin_ff(pin),
		.o_rx_accept_own_ff());

	task chk(input [39:0] got, input [39:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr_reg(input [1:0] a, input [3:0] b, input [31:0] d);
		host_u.xfer(1'b0, a, b, d, q);
	endtask
	task rd_reg(input [1:0] a, input [3:0] b, input [31:0] exp);
		begin
			host_u.xfer(1'b1, a, b, 32'h0000_0000, q);
			chk({8'h00, q}, {8'h00, exp});
		end
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", n_tests, err_count);
			if (err_count == 0 && n_tests > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	// ==========================================================
	// clock, reset and watchdog
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_count = err_count + 1;
		close_out;
	end
	// ==========================================================
	// main sequence
	initial begin
		{rst_n, queued, mii_sel, mii_crs, rx_v, rx_e} = 6'h00;
		byte_cnt = 11'h000;
		tx_d = 8'h00;
		{c55, cd5, cdat, cpad, cdone} = 40'h00_0000_0000;
		err_count = 0;
		n_tests = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(2'h0, 4'hf, 32'h0000_0000);
		rd_reg(2'h3, 4'hc, 32'h5a00_0000);
		wr_reg(2'h3, 4'hf, 32'h0003_ffff);
		rd_reg(2'h3, 4'hf, 32'h5a03_0000);
		wr_reg(2'h0, 4'h3, 32'h0000_ffff);
		wr_reg(2'h3, 4'h4, 32'h0007_0000);
		rd_reg(2'h0, 4'hf, 32'h0000_0000);
		chk({39'h0, ext_n}, 40'h00_0000_0000);
		wr_reg(2'h3, 4'h4, 32'h0000_0000);
		rd_reg(2'h0, 4'h3, 32'h0000_0000);
		// internal loopback with the phy loopback pin
		wr_reg(2'h0, 4'h3, 32'h0000_2002);
		@(posedge clk);
		{rx_v, rx_e, mii_crs} <= 3'h7;
		repeat (3) @(posedge clk);
		#1 chk({26'h0, rxv, rxe, mtx, stx, txd, oct, pin}, 40'h00_0000_0201);
		rd_reg(2'h1, 4'h3, 32'h0000_0000);
		rd_reg(2'h0, 4'h2, 32'h0000_2000);
		// full duplex frame of 4 bytes under carrier, padded, no crc
		@(posedge clk);
		{mii_sel, rx_v, rx_e} <= 3'h4;
		byte_cnt <= 11'h004;
		tx_d <= 8'h3c;
		queued <= 1'b1;
		wr_reg(2'h0, 4'h3, 32'h0000_8181);
		for (i = 0; i < 400; i = i + 1) begin
			@(posedge clk);
			if (ready)
				queued <= 1'b0;
			if (done)
				cdone = cdone + 8'h01;
			if (mtx)
				case (oct)
					8'h55: c55 = c55 + 8'h01;
					8'hd5: cd5 = cd5 + 8'h01;
					8'h3c: cdat = cdat + 8'h01;
					8'h00: cpad = cpad + 8'h01;
					default: cdone = cdone + 8'h10;
				endcase
		end
		chk({c55, cd5, cdat, cpad, cdone}, 40'h07_0104_3c01);
		rd_reg(2'h0, 4'h4, 32'h0040_0000);
		// serial frame, carrier monitor on, no carrier: abort, flag, self-disable
		wr_reg(2'h0, 4'h3, 32'h0000_0401);
		@(posedge clk);
		{mii_sel, queued} <= 2'h1;
		repeat (20) @(posedge clk);
		rd_reg(2'h0, 4'hf, 32'h0400_0400);
		close_out;
	end
endmodule
